// [rtl/tfcrf_regfile.sv]
// Purpose: Register file of the first edge FPGA, serial bus side
// Assumes: Serial bus slave outside delivers sub-address, strobes, data
// Notes:   Strobe bits give one-cycle pulses toward the sequencer and staging sram
`timescale 1ns/100ps
`default_nettype none
module tfcrf_regfile
  import tfcrf_pkg::*;
#(
  parameter logic [14:0] FW_VERSION = 15'h0001  // Arbitrary default
)
(
  input  wire logic                            clk,            // 250 MHz clock
  input  wire logic                            arst_n,         // Async reset
  // Register access from the serial bus slave
  input  wire logic [tfcrf_pkg::AW-1:0]        reg_addr,       // Sub-address
  input  wire logic                            reg_wr,         // Write strobe
  input  wire logic [tfcrf_pkg::DW-1:0]        reg_wdata,      // Write data
  input  wire logic                            reg_rd,         // Read strobe
  output logic      [tfcrf_pkg::DW-1:0]        reg_rdata,      // Read data
  output logic                                 reg_rvalid,     // Read data valid
  // Transceiver and monitor status
  input  wire logic [tfcrf_pkg::NLANE-1:0]     lane_up,        // Lane up flags
  input  wire logic [tfcrf_pkg::NSLOT-1:0]     chan_up,        // Channel up flags
  input  wire logic [tfcrf_pkg::DW-1:0]        die_temp,       // Die temperature
  input  wire logic [tfcrf_pkg::DW-1:0]        core_volt,      // Core voltage
  // Receive path control
  output logic      [tfcrf_pkg::NSLOT-1:0]     payload_en,     // Slot enables
  output logic                                 align_en,       // Align on sync
  output logic                                 xcvr_init,      // Init transceivers
  // Configuration sequencer
  output tfcrf_pkg::tfcrf_target_t             cfg_target,     // Target FPGA
  output logic      [3:0]                      cfg_opcode,     // Opcode field
  output logic                                 cfg_opcode_ok,  // Opcode defined
  output logic                                 cfg_sram_sel,   // Sram is dest
  output logic                                 cfg_execute,    // Execute pulse
  output logic      [tfcrf_pkg::ERASE_W-1:0]   erase_block,    // Erase block
  input  wire logic                            seq_idle,       // Sequencer idle
  // Staging sram
  output logic      [tfcrf_pkg::DW-1:0]        sram_wdata,     // Write data
  output logic      [tfcrf_pkg::SADDR_W-1:0]   sram_addr,      // Address
  output logic                                 sram_wr,        // Write pulse
  output logic                                 sram_rd,        // Read pulse
  input  wire logic [tfcrf_pkg::DW-1:0]        sram_rdata,     // Read data
  input  wire logic                            sram_rvalid     // Read data valid
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NSLOT-1:0]      pen;
    logic                  align;
    logic                  init;
    logic [1:0]            target;
    logic                  exec;
    logic                  sram_sel;
    logic [3:0]            opcode;
    logic [ERASE_W-1:0]    erase;
    logic [DW-1:0]         wdata;
    logic [DW-1:0]         addr_lo;
    logic [SADDR_HI_W-1:0] addr_hi;
    logic                  swr;
    logic                  srd;
    logic [DW-1:0]         rdata_sram;
    logic [DW-1:0]         rdata;
    logic                  rvalid;
    logic                  exec_pls;
    logic                  swr_pls;
    logic                  srd_pls;
  } tfcrf_st_t;

  tfcrf_st_t st_q;
  tfcrf_st_t st_d;

  logic [NSTROBE-1:0] strobe_lvl;
  logic [NSTROBE-1:0] strobe_pls;
  logic [DW-1:0]      rd_word;
  logic [DW-1:0]      pen_word;
  logic [DW-1:0]      ctl_word;
  logic [DW-1:0]      cmd_word;
  logic [DW-1:0]      erase_word;
  logic [DW-1:0]      addrh_word;
  logic [DW-1:0]      idle_word;

  // ----------------------------------------------------------------
  // Read-back views of stored fields
  // ----------------------------------------------------------------

  // Payload enables sit on even bits 6..14
  always_comb
  begin
    pen_word = RST_WORD;
    for (int i = 0; i < NSLOT; i++)
    begin
      pen_word[PEN_LSB + 2*i] = st_q.pen[i];
    end
  end

  // Align and init bits
  always_comb
  begin
    ctl_word            = RST_WORD;
    ctl_word[ALIGN_BIT] = st_q.align;
    ctl_word[INIT_BIT]  = st_q.init;
  end

  // Configuration command word
  always_comb
  begin
    cmd_word                  = RST_WORD;
    cmd_word[TGT_LSB +: 2]    = st_q.target;
    cmd_word[EXEC_BIT]        = st_q.exec;
    cmd_word[SRAM_SEL_BIT]    = st_q.sram_sel;
    cmd_word[OPC_LSB +: 4]    = st_q.opcode;
  end

  // Erase block, high sram address and strobes
  always_comb
  begin
    erase_word                 = RST_WORD;
    erase_word[ERASE_W-1:0]    = st_q.erase;
    addrh_word                 = RST_WORD;
    addrh_word[SWR_BIT]        = st_q.swr;
    addrh_word[SRD_BIT]        = st_q.srd;
    addrh_word[SADDR_HI_W-1:0] = st_q.addr_hi;
  end

  // Idle flag over firmware version
  always_comb
  begin
    idle_word           = {1'b0, FW_VERSION};
    idle_word[IDLE_BIT] = seq_idle;
  end

  // ----------------------------------------------------------------
  // Read selection
  // ----------------------------------------------------------------

  // Word chosen by sub-address
  tfcrf_read_mux u_read_mux (
    .addr       (reg_addr),
    .lane_up    (lane_up),
    .chan_up    (chan_up),
    .die_temp   (die_temp),
    .core_volt  (core_volt),
    .pen_word   (pen_word),
    .ctl_word   (ctl_word),
    .cmd_word   (cmd_word),
    .erase_word (erase_word),
    .wdata_word (st_q.wdata),
    .addrl_word (st_q.addr_lo),
    .addrh_word (addrh_word),
    .rdata_word (st_q.rdata_sram),
    .idle_word  (idle_word),
    .word       (rd_word)
  );

  // ----------------------------------------------------------------
  // Strobe edge detection
  // ----------------------------------------------------------------

  // Execute, sram write, sram read levels
  assign strobe_lvl = {st_q.srd, st_q.swr, st_q.exec};

  // Rising steps become single pulses
  tfcrf_rise_pulse u_rise_pulse (
    .clk    (clk),
    .arst_n (arst_n),
    .level  (strobe_lvl),
    .pulse  (strobe_pls)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;

    // Registered read answer, one cycle after the strobe
    st_d.rvalid = reg_rd;
    if (reg_rd)
    begin
      st_d.rdata = rd_word;
    end

    // Registered strobe pulses toward sequencer and sram
    st_d.exec_pls = strobe_pls[0];
    st_d.swr_pls  = strobe_pls[1];
    st_d.srd_pls  = strobe_pls[2];

    // Capture the word of the last sram read
    if (sram_rvalid)
    begin
      st_d.rdata_sram = sram_rdata;
    end

    // Writes; read-only addresses fall through untouched
    if (reg_wr)
    begin
      unique case (reg_addr)
        ADDR_PAYLOAD_EN:
        begin
          for (int i = 0; i < NSLOT; i++)
          begin
            st_d.pen[i] = reg_wdata[PEN_LSB + 2*i];
          end
        end
        ADDR_ALIGN_INIT:
        begin
          st_d.align = reg_wdata[ALIGN_BIT];
          st_d.init  = reg_wdata[INIT_BIT];
        end
        ADDR_CFG_CMD:
        begin
          st_d.target   = reg_wdata[TGT_LSB +: 2];
          st_d.exec     = reg_wdata[EXEC_BIT];
          st_d.sram_sel = reg_wdata[SRAM_SEL_BIT];
          st_d.opcode   = reg_wdata[OPC_LSB +: 4];
        end
        ADDR_ERASE_BLK:
        begin
          st_d.erase = reg_wdata[ERASE_W-1:0];
        end
        ADDR_SRAM_WDATA:
        begin
          st_d.wdata = reg_wdata;
        end
        ADDR_SRAM_ADDR_L:
        begin
          st_d.addr_lo = reg_wdata;
        end
        ADDR_SRAM_ADDR_H:
        begin
          st_d.swr     = reg_wdata[SWR_BIT];
          st_d.srd     = reg_wdata[SRD_BIT];
          st_d.addr_hi = reg_wdata[SADDR_HI_W-1:0];
        end
        default:
        begin
          st_d.rvalid = st_d.rvalid;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Bus answer
  assign reg_rdata  = st_q.rdata;
  assign reg_rvalid = st_q.rvalid;

  // Receive path control
  assign payload_en = st_q.pen;
  assign align_en   = st_q.align;
  assign xcvr_init  = st_q.init;

  // Sequencer command fields
  assign cfg_target    = tfcrf_target_t'(st_q.target);
  assign cfg_opcode    = st_q.opcode;
  assign cfg_opcode_ok = (st_q.opcode <= OPC_LAST_DEFINED);
  assign cfg_sram_sel  = st_q.sram_sel;
  assign cfg_execute   = st_q.exec_pls;
  assign erase_block   = st_q.erase;

  // Staging sram
  assign sram_wdata = st_q.wdata;
  assign sram_addr  = {st_q.addr_hi, st_q.addr_lo};
  assign sram_wr    = st_q.swr_pls;
  assign sram_rd    = st_q.srd_pls;

endmodule // tfcrf_regfile
`default_nettype wire

// [rtl/tfcrf_pkg.sv]
// Purpose: Shared constants for the trigger FPGA configuration register file
// Assumes: 16-bit registers reached by 5-bit sub-address
// Notes:   Offsets, field positions, reset values and codes live here
package tfcrf_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned DW      = 16;   // Register width
  localparam int unsigned AW      = 5;    // Sub-address width
  localparam int unsigned NSLOT   = 5;    // Served payload slots
  localparam int unsigned NLANE   = 10;   // Two lanes per slot
  localparam int unsigned NSTROBE = 3;    // Execute, sram write, sram read
  localparam int unsigned SADDR_W = 22;   // Staging sram address

  // ----------------------------------------------------------------
  // Sub-addresses
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] ADDR_LANE_STATUS = 5'h00;
  localparam logic [AW-1:0] ADDR_COMB_STATUS = 5'h01;
  localparam logic [AW-1:0] ADDR_PAYLOAD_EN  = 5'h02;
  localparam logic [AW-1:0] ADDR_ALIGN_INIT  = 5'h03;
  localparam logic [AW-1:0] ADDR_DIE_TEMP    = 5'h04;
  localparam logic [AW-1:0] ADDR_CORE_VOLT   = 5'h05;
  localparam logic [AW-1:0] ADDR_CFG_CMD     = 5'h06;
  localparam logic [AW-1:0] ADDR_ERASE_BLK   = 5'h07;
  localparam logic [AW-1:0] ADDR_SRAM_WDATA  = 5'h08;
  localparam logic [AW-1:0] ADDR_SRAM_ADDR_L = 5'h09;
  localparam logic [AW-1:0] ADDR_SRAM_ADDR_H = 5'h0a;
  localparam logic [AW-1:0] ADDR_SRAM_RDATA  = 5'h0b;
  localparam logic [AW-1:0] ADDR_IDLE_VER    = 5'h11;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CHAN_UP_LSB   = 12;  // Status 0 channel-up field
  localparam int unsigned ALL_UP_BIT    = 1;   // Status 1 combined
  localparam int unsigned SLOT5_UP_BIT  = 0;   // Status 1 fifth slot
  localparam int unsigned PEN_LSB       = 6;   // Payload enables at 6,8,..,14
  localparam int unsigned ALIGN_BIT     = 3;
  localparam int unsigned INIT_BIT      = 1;
  localparam int unsigned TGT_LSB       = 9;   // Bits 10..9
  localparam int unsigned EXEC_BIT      = 8;
  localparam int unsigned SRAM_SEL_BIT  = 7;
  localparam int unsigned OPC_LSB       = 3;   // Bits 6..3
  localparam int unsigned ERASE_W       = 10;
  localparam int unsigned SWR_BIT       = 15;
  localparam int unsigned SRD_BIT       = 14;
  localparam int unsigned SADDR_HI_W    = 6;
  localparam int unsigned IDLE_BIT      = 15;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DW-1:0] RST_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TGT_NONE            = 2'h0,
    TGT_FIRST_EDGE_FPGA = 2'h1,
    TGT_SECOND_EDGE_FPGA = 2'h2,
    TGT_CENTRAL_FPGA    = 2'h3
  } tfcrf_target_t;

  localparam logic [3:0] OPC_PROGRAM_ROM_FIRST_EDGE = 4'h0;  // 0..2 program
  localparam logic [3:0] OPC_READ_ROM_FIRST_EDGE    = 4'h3;  // 3..5 read back
  localparam logic [3:0] OPC_READ_ROM_ID_FIRST_EDGE = 4'h6;  // 6..8 identifier
  localparam logic [3:0] OPC_ERASE_ROM_FIRST_EDGE   = 4'h9;  // 9..B erase
  localparam logic [3:0] OPC_LAST_DEFINED           = 4'hb;

endpackage

// [rtl/tfcrf_rise_pulse.sv]
// Purpose: Rising-edge pulse generator for the strobe bits
// Assumes: Levels come from flip-flops in the same clock domain
// Notes:   One pulse per zero-to-one step, never on a held level
`timescale 1ns/100ps
`default_nettype none
module tfcrf_rise_pulse
  import tfcrf_pkg::*;
(
  input  wire logic                             clk,     // System clock
  input  wire logic                             arst_n,  // Async reset
  input  wire logic [tfcrf_pkg::NSTROBE-1:0]    level,   // Strobe levels
  output logic      [tfcrf_pkg::NSTROBE-1:0]    pulse    // One-cycle pulses
);

  typedef struct packed {
    logic [NSTROBE-1:0] prev;
  } tfcrf_edge_st_t;

  tfcrf_edge_st_t st_q;
  tfcrf_edge_st_t st_d;

  // Previous-cycle copy
  always_comb
  begin
    st_d      = st_q;
    st_d.prev = level;
  end

  // Compare with last cycle, one bit each
  for (genvar i = 0; i < NSTROBE; i++)
  begin : g_edge
    assign pulse[i] = level[i] & ~st_q.prev[i];
  end

  // State register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

endmodule // tfcrf_rise_pulse
`default_nettype wire

// [rtl/tfcrf_read_mux.sv]
// Purpose: Read-back word selection by sub-address
// Assumes: Stored fields and status inputs are stable this cycle
// Notes:   Unmapped sub-addresses and undefined bits return zero
`timescale 1ns/100ps
`default_nettype none
module tfcrf_read_mux
  import tfcrf_pkg::*;
(
  input  wire logic [tfcrf_pkg::AW-1:0]       addr,        // Sub-address
  input  wire logic [tfcrf_pkg::NLANE-1:0]    lane_up,     // Lane up flags
  input  wire logic [tfcrf_pkg::NSLOT-1:0]    chan_up,     // Channel up flags
  input  wire logic [tfcrf_pkg::DW-1:0]       die_temp,    // Temperature word
  input  wire logic [tfcrf_pkg::DW-1:0]       core_volt,   // Core voltage word
  input  wire logic [tfcrf_pkg::DW-1:0]       pen_word,    // Payload enable view
  input  wire logic [tfcrf_pkg::DW-1:0]       ctl_word,    // Align/init view
  input  wire logic [tfcrf_pkg::DW-1:0]       cmd_word,    // Config command view
  input  wire logic [tfcrf_pkg::DW-1:0]       erase_word,  // Erase block view
  input  wire logic [tfcrf_pkg::DW-1:0]       wdata_word,  // Sram write data
  input  wire logic [tfcrf_pkg::DW-1:0]       addrl_word,  // Sram address low
  input  wire logic [tfcrf_pkg::DW-1:0]       addrh_word,  // Sram address high
  input  wire logic [tfcrf_pkg::DW-1:0]       rdata_word,  // Sram read data
  input  wire logic [tfcrf_pkg::DW-1:0]       idle_word,   // Idle and version
  output logic      [tfcrf_pkg::DW-1:0]       word         // Selected word
);

  // Address decode
  always_comb
  begin
    word = RST_WORD;
    unique case (addr)
      ADDR_LANE_STATUS:
      begin
        word[CHAN_UP_LSB +: 4] = chan_up[3:0];
        word[NLANE-1:0]        = lane_up;
      end
      ADDR_COMB_STATUS:
      begin
        word[ALL_UP_BIT]   = &chan_up;
        word[SLOT5_UP_BIT] = chan_up[4];
      end
      ADDR_PAYLOAD_EN:  word = pen_word;
      ADDR_ALIGN_INIT:  word = ctl_word;
      ADDR_DIE_TEMP:    word = die_temp;
      ADDR_CORE_VOLT:   word = core_volt;
      ADDR_CFG_CMD:     word = cmd_word;
      ADDR_ERASE_BLK:   word = erase_word;
      ADDR_SRAM_WDATA:  word = wdata_word;
      ADDR_SRAM_ADDR_L: word = addrl_word;
      ADDR_SRAM_ADDR_H: word = addrh_word;
      ADDR_SRAM_RDATA:  word = rdata_word;
      ADDR_IDLE_VER:    word = idle_word;
      default:          word = RST_WORD;
    endcase
  end

endmodule // tfcrf_read_mux
`default_nettype wire

// [verification/tfcrf_regfile_chk.sv]
// Purpose: Port assertions for the register file
// Assumes: Bound to every tfcrf_regfile instance
// Notes:   Helper flags mirror the three strobe bit levels
`timescale 1ns/100ps
`default_nettype none
module tfcrf_regfile_chk
  import tfcrf_pkg::*;
#(
  parameter logic [14:0] FW_VERSION = 15'h0001  // Arbitrary default
)
(
  input wire logic                 clk,           // System clock
  input wire logic                 arst_n,        // Async reset
  input wire logic [4:0]           reg_addr,      // Sub-address
  input wire logic                 reg_wr,        // Write strobe
  input wire logic [15:0]          reg_wdata,     // Write data
  input wire logic                 reg_rd,        // Read strobe
  input wire logic [15:0]          reg_rdata,     // Read data
  input wire logic                 reg_rvalid,    // Read valid
  input wire logic                 seq_idle,      // Sequencer idle
  input wire logic [4:0]           payload_en,    // Slot enables
  input wire logic [1:0]           cfg_target,    // Target FPGA
  input wire logic [3:0]           cfg_opcode,    // Opcode
  input wire logic                 cfg_sram_sel,  // Sram destination
  input wire logic                 cfg_execute,   // Execute pulse
  input wire logic [9:0]           erase_block,   // Erase block
  input wire logic [15:0]          sram_wdata,    // Sram data
  input wire logic [21:0]          sram_addr,     // Sram address
  input wire logic                 sram_wr,       // Sram write pulse
  input wire logic                 sram_rd        // Sram read pulse
);
  logic [2:0] lvl_q;  // Exec, sram write, sram read levels
  logic       w6;
  logic       w10;
  // ----------------------------------------------------------------
  // Strobe level mirror
  // ----------------------------------------------------------------
  assign w6 = reg_wr && reg_addr == 5'h06;
  assign w10 = reg_wr && reg_addr == 5'h0a;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      lvl_q <= 3'h0;
    else if (w6)
      lvl_q[0] <= reg_wdata[8];
    else if (w10)
      lvl_q[2:1] <= {reg_wdata[14], reg_wdata[15]};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_exec_rise: assert property (w6 && reg_wdata[8] && !lvl_q[0] |-> ##2 cfg_execute)
    else $error("execute pulse missing");
  a_exec_cause: assert property (cfg_execute |-> $past(w6 && reg_wdata[8] && !lvl_q[0], 2))
    else $error("execute pulse without rising write");
  a_exec_once: assert property (cfg_execute |=> !cfg_execute)
    else $error("execute pulse too long");
  a_swr_rise: assert property (w10 && reg_wdata[15] && !lvl_q[1] |-> ##2 sram_wr)
    else $error("sram write pulse missing");
  a_srd_rise: assert property (w10 && reg_wdata[14] && !lvl_q[2] |-> ##2 sram_rd)
    else $error("sram read pulse missing");
  a_cmd_fields: assert property (w6 |=> {cfg_target, cfg_sram_sel, cfg_opcode} ==
    {$past(reg_wdata[10:9]), $past(reg_wdata[7:3])})
    else $error("command fields wrong");
  a_addr_form: assert property (w10 |=> sram_addr[21:16] == $past(reg_wdata[5:0]) && $stable(sram_addr[15:0]))
    else $error("sram address wrong");
  a_idle_read: assert property (reg_rd && reg_addr == 5'h11 |=> reg_rvalid && reg_rdata == {$past(seq_idle), FW_VERSION})
    else $error("idle word wrong");
  a_ro_ignore: assert property (reg_wr && reg_addr inside {5'h00, 5'h01, 5'h04, 5'h05, 5'h0b, 5'h11}
    |=> $stable({payload_en, erase_block, sram_wdata, cfg_opcode}))
    else $error("read-only write changed state");
  a_pen_map: assert property (reg_wr && reg_addr == 5'h02 |=> payload_en ==
    $past({reg_wdata[14], reg_wdata[12], reg_wdata[10], reg_wdata[8], reg_wdata[6]}))
    else $error("payload enables wrong");
endmodule // tfcrf_regfile_chk
bind tfcrf_regfile tfcrf_regfile_chk #(.FW_VERSION(FW_VERSION)) i_tfcrf_regfile_chk (.*);
`default_nettype wire

// [verification/tfcrf_seq_model.sv]
// Purpose: Sequencer and staging sram stand-in
// Assumes: Pulses from the register file are one cycle long
// Notes:   Read data toggles while not valid
`timescale 1ns/100ps
`default_nettype none
module tfcrf_seq_model #(
  parameter int BUSY = 12  // Busy cycles per opcode
)
(
  input  wire logic        clk,          // System clock
  input  wire logic        arst_n,       // Async reset
  input  wire logic        cfg_execute,  // Execute pulse
  input  wire logic        sram_wr,      // Write pulse
  input  wire logic        sram_rd,      // Read pulse
  input  wire logic [21:0] sram_addr,    // Address
  input  wire logic [15:0] sram_wdata,   // Write data
  output logic             seq_idle,     // Idle flag
  output logic      [15:0] sram_rdata,   // Read data
  output logic             sram_rvalid   // Read valid
);
  logic [15:0] mem [logic [21:0]];
  logic [15:0] d_q;
  logic [1:0]  rd_q;
  int          busy;
  // Busy count, memory and delayed read answer
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy <= 0;
      rd_q <= 2'h0;
      sram_rvalid <= 1'b0;
      sram_rdata <= 16'h0000;
    end
    else
    begin
      busy <= cfg_execute ? BUSY : (busy > 0 ? busy - 1 : 0);
      if (sram_wr)
        mem[sram_addr] = sram_wdata;
      if (sram_rd)
        d_q <= mem.exists(sram_addr) ? mem[sram_addr] : 16'h0000;
      rd_q <= {rd_q[0], sram_rd};
      sram_rvalid <= rd_q[1];
      sram_rdata <= rd_q[1] ? d_q : ~sram_rdata;
    end
  end
  assign seq_idle = arst_n && busy == 0;  // Idle when no opcode runs
endmodule // tfcrf_seq_model
`default_nettype wire

// [verification/tb_top.sv]
// Purpose: Self-checking bench for the register file
// Assumes: Strobe register port, model on the sequencer side
// Notes:   Row table first, then strobes, sram and reset
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import tfcrf_pkg::*;
  typedef struct packed { logic [4:0] a; logic [15:0] w; logic [15:0] e; } tfcrf_row_t;
  localparam tfcrf_row_t ROWS [15] = '{
    '{5'h00, 16'hffff, 16'hb2a5}, '{5'h01, 16'hffff, 16'h0001}, '{5'h04, 16'hffff, 16'h1357},
    '{5'h05, 16'hffff, 16'h2468}, '{5'h11, 16'hffff, 16'hab3c}, '{5'h0c, 16'hffff, 16'h0000},
    '{5'h1f, 16'hffff, 16'h0000}, '{5'h02, 16'hffff, 16'h5540}, '{5'h03, 16'hffff, 16'h000a},
    '{5'h07, 16'hffff, 16'h03ff}, '{5'h08, 16'ha5c3, 16'ha5c3}, '{5'h09, 16'h1234, 16'h1234},
    '{5'h06, 16'hffff, 16'h07f8}, '{5'h0b, 16'hffff, 16'h0000}, '{5'h0a, 16'hffff, 16'hc03f}};
  logic clk, arst_n, reg_wr, reg_rd, reg_rvalid, align_en, xcvr_init, cfg_opcode_ok, cfg_sram_sel;
  logic cfg_execute, seq_idle, sram_wr, sram_rd, sram_rvalid;
  logic [4:0]  reg_addr, payload_en;
  logic [15:0] reg_wdata, reg_rdata, sram_wdata, sram_rdata, d, w;
  logic [3:0]  cfg_opcode;
  logic [9:0]  erase_block;
  logic [21:0] sram_addr;
  logic [1:0]  t;
  tfcrf_target_t cfg_target;
  int failures, checks_done, n_exec, n0, n, op;
  tfcrf_regfile #(.FW_VERSION(15'h2b3c)) i_tfcrf_regfile (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .lane_up(10'h2a5), .chan_up(5'h1b), .die_temp(16'h1357), .core_volt(16'h2468),
    .payload_en(payload_en), .align_en(align_en), .xcvr_init(xcvr_init), .cfg_target(cfg_target),
    .cfg_opcode(cfg_opcode), .cfg_opcode_ok(cfg_opcode_ok), .cfg_sram_sel(cfg_sram_sel),
    .cfg_execute(cfg_execute), .erase_block(erase_block), .seq_idle(seq_idle), .sram_wdata(sram_wdata),
    .sram_addr(sram_addr), .sram_wr(sram_wr), .sram_rd(sram_rd), .sram_rdata(sram_rdata),
    .sram_rvalid(sram_rvalid));
  tfcrf_seq_model i_tfcrf_seq_model (.clk(clk), .arst_n(arst_n), .cfg_execute(cfg_execute),
    .sram_wr(sram_wr), .sram_rd(sram_rd), .sram_addr(sram_addr), .sram_wdata(sram_wdata),
    .seq_idle(seq_idle), .sram_rdata(sram_rdata), .sram_rvalid(sram_rvalid));
  // Clock, pulse counter and watchdog
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
    if (cfg_execute === 1'b1)
      n_exec++;
  initial
  begin
    #100000;
    failures++;
    conclude();
  end
  // Register writes, optionally held for a back-to-back write
  task automatic wr(input logic [4:0] a, input logic [15:0] v, input logic keep = 1'b0);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    if (!keep)
    begin
      reg_wr = 1'b0;
      @(negedge clk);
    end
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    v = reg_rdata;
    @(negedge clk);
  endtask
  task automatic chk_w(input logic [21:0] g, input logic [21:0] e);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    foreach (ROWS[i])
    begin
      wr(ROWS[i].a, ROWS[i].w);
      rd(ROWS[i].a, d);
      chk_w(d, ROWS[i].e);
    end
    chk_w({payload_en, align_en, xcvr_init, erase_block}, {5'h1f, 2'h3, 10'h3ff});
    $display("row table done");
    wr(5'h06, 16'h0000);
    n0 = n_exec;
    for (op = 0; op < 16; op++)
    begin
      t = 2'(op % 3 + 1);
      w = {5'h00, t, 1'b1, 1'(op), 4'(op), 3'h0};
      wr(5'h06, w);
      chk_w({cfg_target, cfg_sram_sel, cfg_opcode, cfg_opcode_ok}, {t, 1'(op), 4'(op), 1'(op < 12)});
      @(negedge clk);
      rd(5'h11, d);
      chk_w(d[15], 1'b0);
      n = 0;
      do
      begin
        rd(5'h11, d);
        n++;
      end while (d[15] !== 1'b1 && n < 40);
      chk_w(d[15], 1'b1);
      wr(5'h06, w & 16'hfeff);
    end
    wr(5'h06, 16'h0118);
    wr(5'h06, 16'h0118);
    wr(5'h06, 16'h0018, 1'b1);
    wr(5'h06, 16'h0118);
    repeat (4) @(negedge clk);
    chk_w(22'(n_exec - n0), 22'd18);
    $display("execute tests done");
    wr(5'h0a, 16'h0000);
    for (int k = 0; k < 2; k++)
    begin
      wr(5'h08, 16'h5a00 | 16'(k));
      wr(5'h09, 16'h1234);
      wr(5'h0a, 16'h8000 | 16'(k + 5));
      chk_w(sram_addr, {6'(k + 5), 16'h1234});
      chk_w(sram_wdata, 16'h5a00 | 16'(k));
      wr(5'h0a, 16'h0000);
    end
    for (int k = 0; k < 2; k++)
    begin
      wr(5'h0a, 16'h4000 | 16'(k + 5));
      for (n = 0; n < 8 && sram_rvalid !== 1'b1; n++)
        @(negedge clk);
      @(negedge clk);
      wr(5'h0a, 16'(k + 5));
      rd(5'h0b, d);
      chk_w(d, 16'h5a00 | 16'(k));
    end
    $display("sram tests done");
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    chk_w({payload_en, align_en, xcvr_init, cfg_execute, sram_wr, sram_rd, erase_block}, 22'h00_0000);
    foreach (ROWS[i])
    begin
      rd(ROWS[i].a, d);
      if (ROWS[i].a inside {5'h02, 5'h03, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b})
        chk_w(d, 16'h0000);
    end
    $display("reset tests done");
    conclude();
  end
endmodule // tb_top
`default_nettype wire
